/* hw/uecr_pkg.sv */
package uecr_pkg;
	// Register byte addresses on the bus (byte address = 4 * index).
	localparam logic [15:0] OFS_SETUP_CMD_LO = 16'h0000;
	localparam logic [15:0] OFS_SETUP_CMD_HI = 16'h0004;
	localparam logic [15:0] OFS_SETUP_DAT_LO = 16'h0008;
	localparam logic [15:0] OFS_SETUP_DAT_HI = 16'h000c;
	localparam logic [15:0] OFS_SETUP_LEN = 16'h0010;
	localparam logic [15:0] OFS_CONTROL = 16'h0014;
	localparam logic [15:0] OFS_ADDR_EP = 16'h0018;
	localparam logic [15:0] OFS_FRAME = 16'h001c;
	localparam logic [15:0] OFS_DESC = 16'h1000;
	localparam logic [15:0] OFS_NAK = 16'h1004;
	localparam logic [15:0] OFS_STALL = 16'h1080;
	localparam logic [15:0] OFS_DL_BASE = 16'h1100;
	localparam logic [15:0] OFS_DL_WPTR = 16'h1180;
	localparam logic [15:0] OFS_REGIO_ADDR = 16'h2000;
	localparam logic [15:0] OFS_REGIO_DATA = 16'h2004;
	localparam logic [15:0] OFS_DESCRIPTOR = 16'h3000;
	// Endpoint description fields.
	localparam int PS_LSB = 0;
	localparam int OUTCOME_LSB = 10;
	localparam int KIND_LSB = 12;
	localparam int DIR_BIT = 14;
	localparam int TOGGLE_BIT = 15;
	// NAK register and stall policy fields.
	localparam int NAK_HALT_BIT = 4;
	localparam int STALL_BULK_LSB = 1;
	localparam int STALL_LIMIT_LSB = 4;
	localparam int STALL_FE_BIT = 8;
	// Control register bit positions.
	localparam int CTL_BOOT_DONE = 0;
	localparam int CTL_REATTACH = 1;
	localparam int CTL_BOOT_RAM = 2;
	localparam int CTL_IRQ = 3;
	localparam int CTL_ISE = 4;
	localparam int CTL_IIN = 5;
	localparam int CTL_IOU = 6;
	localparam int CTL_FAULT = 7;
	// Register I/O address fields.
	localparam int RIO_START = 15;
	localparam int RIO_WRITE = 14;
	// Reset values.
	localparam logic [17:0] WPTR_MINUS_ONE = 18'h3ffff;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
	// Default device descriptor, 18 bytes packed low byte first.
	localparam logic [7:0] DD_LENGTH = 8'h12;
	localparam logic [15:0] DD_BCD_USB = 16'h0110;
	localparam logic [7:0] DD_CLASS = 8'hff;
	localparam logic [7:0] DD_EP0_SIZE = 8'h08;
	localparam logic [7:0] DD_NUM_CONFIG = 8'h01;
	typedef enum logic [1:0] {UECR_OUT_CLEAR, UECR_OUT_ACK, UECR_OUT_NAK, UECR_OUT_ERR} uecr_outcome_t;
	typedef enum logic [1:0] {UECR_EP_DISABLED, UECR_EP_ISO, UECR_EP_BULK, UECR_EP_INTR} uecr_kind_t;
endpackage

/* hw/uecr_ep_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Per-endpoint transaction events from the USB engine to one endpoint slice.
interface uecr_ep_if;
	logic done;
	uecr_pkg::uecr_outcome_t outcome;
	logic toggle;
	logic fifo_fault;
	logic [15:0] desc;
	logic [4:0] nak;
	logic short_pkt;
	logic halted;
	modport core(output done, output outcome, output toggle, output fifo_fault, input desc, input nak,
		input short_pkt, input halted);
	modport slice(input done, input outcome, input toggle, input fifo_fault, output desc, output nak,
		output short_pkt, output halted);
endinterface
`default_nettype wire

/* hw/uecr_ep_slice.sv */
`timescale 1ns/1ps
`default_nettype none
// One programmable endpoint: description and NAK/halt register.
module uecr_ep_slice (
	input wire logic clk_i,
	input wire logic rst_i,
	uecr_ep_if.slice ep,
	input wire logic desc_we_i,
	input wire logic nak_we_i,
	input wire logic [15:0] wdata_i,
	input wire logic [3:0] refusal_limit_i,
	input wire logic overflow_halt_policy_i
);
	logic [9:0] max_packet_size;
	uecr_pkg::uecr_outcome_t prior_outcome;
	uecr_pkg::uecr_kind_t endpoint_kind;
	logic endpoint_direction;
	logic data_toggle_state;
	logic [3:0] nak_run;
	logic halted_flag;

	// Software-owned configuration fields.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			max_packet_size <= 10'h000;
			endpoint_kind <= uecr_pkg::UECR_EP_DISABLED;
			endpoint_direction <= 1'b0;
		end else if (desc_we_i) begin
			max_packet_size <= wdata_i[uecr_pkg::PS_LSB +: 10]; // [RULE1]
			endpoint_kind <= uecr_pkg::uecr_kind_t'(wdata_i[uecr_pkg::KIND_LSB +: 2]); // [RULE3]
			endpoint_direction <= wdata_i[uecr_pkg::DIR_BIT]; // [RULE3]
		end
	end

	// Outcome and toggle follow the engine; an engine event beats a software write.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prior_outcome <= uecr_pkg::UECR_OUT_CLEAR;
			data_toggle_state <= 1'b0;
		end else if (ep.done) begin
			prior_outcome <= ep.outcome; // [RULE2]
			data_toggle_state <= ep.toggle; // [RULE2]
		end else if (desc_we_i) begin
			prior_outcome <= uecr_pkg::uecr_outcome_t'(wdata_i[uecr_pkg::OUTCOME_LSB +: 2]);
			data_toggle_state <= wdata_i[uecr_pkg::TOGGLE_BIT];
		end
	end

	// Consecutive NAK run; restarts after any non-NAK outcome or a short packet.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nak_run <= 4'h0;
		end else if (ep.done) begin
			if (ep.outcome == uecr_pkg::UECR_OUT_NAK && !ep.short_pkt) begin
				nak_run <= nak_run + 4'h1; // [RULE4]
			end else begin
				nak_run <= 4'h0;
			end
		end else if (nak_we_i) begin
			nak_run <= wdata_i[3:0];
		end
	end

	// Halt: a FIFO fault under the stall policy sets it, and wins over a write.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			halted_flag <= 1'b0;
		end else if (ep.fifo_fault && overflow_halt_policy_i) begin
			halted_flag <= 1'b1; // [RULE6]
		end else if (nak_we_i) begin
			halted_flag <= wdata_i[uecr_pkg::NAK_HALT_BIT]; // [RULE5]
		end
	end

	assign ep.short_pkt = (nak_run == refusal_limit_i); // [RULE4]
	assign ep.halted = halted_flag;
	assign ep.desc = {data_toggle_state, endpoint_direction, endpoint_kind, prior_outcome, max_packet_size};
	assign ep.nak = {halted_flag, nak_run};

	AST_HALT_ON_FAULT: assert property (@(posedge clk_i) disable iff (rst_i)
		ep.fifo_fault && overflow_halt_policy_i |=> halted_flag) else $error("fault did not halt"); // [RULE6]
	AST_NAK_COUNT: assert property (@(posedge clk_i) disable iff (rst_i)
		ep.done && ep.outcome == uecr_pkg::UECR_OUT_NAK && !ep.short_pkt |=> nak_run == $past(nak_run) + 4'h1)
		else $error("nak run not counted"); // [RULE4]
	AST_OUTCOME: assert property (@(posedge clk_i) disable iff (rst_i)
		ep.done |=> prior_outcome == $past(ep.outcome)) else $error("outcome not recorded"); // [RULE2]
endmodule
`default_nettype wire

/* hw/uecr_regs.sv */
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE1] Ten-bit max packet size per endpoint, read/write.
// [RULE2] Two-bit last outcome plus data toggle bit.
// [RULE3] Two-bit endpoint kind and direction bit.
// [RULE4] Four-bit NAK run; short packet at limit.
// [RULE5] Per-endpoint and bulk halt flags, bit n.
// [RULE6] FIFO fault halts endpoint when policy set.
// [RULE7] Three 18-bit download base registers.
// [RULE8] Read-only offset; base plus offset last written.
// [RULE9] Base write sets offset to all ones.
// [RULE10] Latest SETUP eight bytes captured read-only.
// [RULE11] SETUP data register shared OUT/IN bytes.
// [RULE12] Four-bit data stage byte count.
// [RULE13] Register I/O address, write bit, start.
// [RULE14] Register I/O data: write value, read result.
// [RULE15] Firmware sets boot complete when ready.
// [RULE16] Reattach write triggers re-enumeration pulse.
// [RULE17] Boot source bit: one RAM, zero ROM.
// [RULE18] Interrupt flag with setup/in/out causes.
// [RULE19] Setup fault stalls endpoint zero.
// [RULE20] Seven-bit address and last endpoint register.
// [RULE21] Eleven-bit last frame number, read-only.
// [RULE22] Fixed 18-byte USB 1.1 device descriptor.
// [RULE23] Start bit clears when access completes.
module uecr_regs #(
	parameter int NUM_EP = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// USB engine events.
	input wire logic [NUM_EP-1:0] ep_done_i,
	input wire logic [2*NUM_EP-1:0] ep_outcome_i,
	input wire logic [NUM_EP-1:0] ep_toggle_i,
	input wire logic [NUM_EP-1:0] ep_fifo_fault_i,
	input wire logic [2:0] bulk_fifo_fault_i,
	input wire logic setup_valid_i,
	input wire logic [63:0] setup_bytes_i,
	input wire logic out_data_valid_i,
	input wire logic [63:0] out_data_i,
	input wire logic [2:0] dl_write_i,
	input wire logic [2:0] irq_cause_i,
	input wire logic irq_clear_i,
	input wire logic sof_valid_i,
	input wire logic [10:0] sof_frame_i,
	input wire logic [3:0] active_ep_i,
	input wire logic regio_done_i,
	input wire logic [15:0] regio_rdata_i,
	// Controls out to the engine.
	output logic [NUM_EP-1:0] ep_halted_o,
	output logic [NUM_EP-1:0] ep_short_pkt_o,
	output logic [2:0] bulk_halted_o,
	output logic ep0_stall_o,
	output logic [63:0] in_data_o,
	output logic [3:0] stage_length_o,
	output logic [6:0] device_address_o,
	output logic ready_o,
	output logic reattach_o,
	output logic boot_from_ram_o,
	output logic regio_start_o,
	output logic regio_write_o,
	output logic [13:0] regio_addr_o,
	output logic [15:0] regio_wdata_o,
	output logic [143:0] descriptor_o
);
	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic req;
	logic wr;
	logic [31:0] wmask;
	logic [31:0] next_rdata;
	logic [15:0] setup_len;
	logic [15:0] ctl;
	logic [15:0] addr_ep;
	logic [10:0] frame_index;
	logic [63:0] setup_cmd;
	logic [63:0] setup_dat;
	logic [15:0] stall_pol;
	logic [17:0] dl_base [3];
	logic [17:0] dl_wptr [3];
	logic [15:0] rio_addr;
	logic [15:0] rio_data;
	logic [15:0] desc_rd [NUM_EP];
	logic [4:0] nak_rd [NUM_EP];
	logic [NUM_EP-1:0] halted_w;
	logic [NUM_EP-1:0] short_w;

	// A new request is only taken while no ack is standing, so every access acks once.
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// Byte-lane merge used by every writable register.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// Index of a per-endpoint word in a bank, or NUM_EP when outside it.
	function automatic int bank_index(input logic [15:0] adr, input logic [15:0] base, input int count);
		int idx;
		idx = count;
		if (adr >= base && adr < base + 16'(8 * count) && adr[2:0] == base[2:0]) begin
			idx = int'((adr - base) >> 3);
		end
		bank_index = idx;
	endfunction

	// ------------------------------------------------------------
	// Endpoint slices
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++) begin : gen_ep
			uecr_ep_if epi();
			assign epi.done = ep_done_i[g];
			assign epi.outcome = uecr_pkg::uecr_outcome_t'(ep_outcome_i[2*g +: 2]);
			assign epi.toggle = ep_toggle_i[g];
			assign epi.fifo_fault = ep_fifo_fault_i[g];
			assign desc_rd[g] = epi.desc;
			assign nak_rd[g] = epi.nak;
			assign halted_w[g] = epi.halted;
			assign short_w[g] = epi.short_pkt;
			uecr_ep_slice u_slice (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.ep(epi.slice),
				.desc_we_i(wr && bank_index(wb_adr_i, uecr_pkg::OFS_DESC, NUM_EP) == g),
				.nak_we_i(wr && bank_index(wb_adr_i, uecr_pkg::OFS_NAK, NUM_EP) == g),
				.wdata_i(16'(merge({16'h0000, desc_rd[g]}, wb_dat_i, wmask))),
				.refusal_limit_i(stall_pol[uecr_pkg::STALL_LIMIT_LSB +: 4]),
				.overflow_halt_policy_i(stall_pol[uecr_pkg::STALL_FE_BIT])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Stall policy and bulk halts
	// ------------------------------------------------------------
	// A FIFO fault on a bulk endpoint under the policy sets its halt and beats a write.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stall_pol <= 16'h0000;
		end else begin
			if (wr && wb_adr_i == uecr_pkg::OFS_STALL) begin
				stall_pol <= 16'(merge({16'h0000, stall_pol}, wb_dat_i, wmask)); // [RULE5]
			end
			if (stall_pol[uecr_pkg::STALL_FE_BIT]) begin
				for (int i = 0; i < 3; i++) begin
					if (bulk_fifo_fault_i[i]) begin
						stall_pol[uecr_pkg::STALL_BULK_LSB + i] <= 1'b1; // [RULE6]
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Code download base and write pointer
	// ------------------------------------------------------------
	// The pointer advances with each written word; a base write restarts it at minus one.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 3; i++) begin
				dl_base[i] <= 18'h00000;
				dl_wptr[i] <= uecr_pkg::WPTR_MINUS_ONE;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (wr && wb_adr_i == uecr_pkg::OFS_DL_BASE + 16'(4 * i)) begin
					dl_base[i] <= 18'(merge({14'h0000, dl_base[i]}, wb_dat_i, wmask)); // [RULE7]
					dl_wptr[i] <= uecr_pkg::WPTR_MINUS_ONE; // [RULE9]
				end else if (dl_write_i[i]) begin
					dl_wptr[i] <= dl_wptr[i] + 18'h00001; // [RULE8]
				end
			end
		end
	end

	// ------------------------------------------------------------
	// SETUP capture, data and length
	// ------------------------------------------------------------
	// Engine data wins over a software write in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			setup_cmd <= 64'h0;
			setup_dat <= 64'h0;
			setup_len <= 16'h0000;
		end else begin
			if (setup_valid_i) begin
				setup_cmd <= setup_bytes_i; // [RULE10]
			end
			if (out_data_valid_i) begin
				setup_dat <= out_data_i; // [RULE11]
			end else if (wr && wb_adr_i == uecr_pkg::OFS_SETUP_DAT_LO) begin
				setup_dat[31:0] <= merge(setup_dat[31:0], wb_dat_i, wmask); // [RULE11]
			end else if (wr && wb_adr_i == uecr_pkg::OFS_SETUP_DAT_HI) begin
				setup_dat[63:32] <= merge(setup_dat[63:32], wb_dat_i, wmask);
			end
			if (wr && wb_adr_i == uecr_pkg::OFS_SETUP_LEN) begin
				setup_len <= 16'(merge({16'h0000, setup_len}, wb_dat_i, wmask)); // [RULE12]
			end
		end
	end

	// ------------------------------------------------------------
	// Control, address and frame
	// ------------------------------------------------------------
	// Interrupt cause bits are set by the engine; the set beats a software clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl <= uecr_pkg::CTL_RESET;
		end else begin
			if (wr && wb_adr_i == uecr_pkg::OFS_CONTROL) begin
				ctl <= 16'(merge({16'h0000, ctl}, wb_dat_i, wmask)); // [RULE15] [RULE17]
			end else if (irq_clear_i) begin
				ctl[uecr_pkg::CTL_IRQ] <= 1'b0;
			end
			if (|irq_cause_i) begin
				ctl[uecr_pkg::CTL_IRQ] <= 1'b1; // [RULE18]
				ctl[uecr_pkg::CTL_ISE] <= irq_cause_i[0];
				ctl[uecr_pkg::CTL_IIN] <= irq_cause_i[1];
				ctl[uecr_pkg::CTL_IOU] <= irq_cause_i[2];
			end
		end
	end

	// Address is software-owned; last active endpoint tracks the engine.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_ep <= 16'h0000;
			frame_index <= 11'h000;
		end else begin
			if (wr && wb_adr_i == uecr_pkg::OFS_ADDR_EP) begin
				addr_ep <= 16'(merge({16'h0000, addr_ep}, wb_dat_i, wmask)); // [RULE20]
			end
			if (setup_valid_i || |irq_cause_i) begin
				addr_ep[11:8] <= active_ep_i; // [RULE20]
			end
			if (sof_valid_i) begin
				frame_index <= sof_frame_i; // [RULE21]
			end
		end
	end

	// ------------------------------------------------------------
	// Register I/O bridge
	// ------------------------------------------------------------
	// Completion clears start so firmware can poll; it wins over a rewrite that cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rio_addr <= 16'h0000;
			rio_data <= 16'h0000;
		end else begin
			if (wr && wb_adr_i == uecr_pkg::OFS_REGIO_ADDR && !rio_addr[uecr_pkg::RIO_START]) begin
				rio_addr <= 16'(merge({16'h0000, rio_addr}, wb_dat_i, wmask)); // [RULE13]
			end
			if (regio_done_i && rio_addr[uecr_pkg::RIO_START]) begin
				rio_addr[uecr_pkg::RIO_START] <= 1'b0; // [RULE23]
				if (!rio_addr[uecr_pkg::RIO_WRITE]) begin
					rio_data <= regio_rdata_i; // [RULE14]
				end
			end else if (wr && wb_adr_i == uecr_pkg::OFS_REGIO_DATA) begin
				rio_data <= 16'(merge({16'h0000, rio_data}, wb_dat_i, wmask)); // [RULE14]
			end
		end
	end

	// ------------------------------------------------------------
	// Read mux and outputs
	// ------------------------------------------------------------
	always_comb begin
		int di;
		int ni;
		di = bank_index(wb_adr_i, uecr_pkg::OFS_DESC, NUM_EP);
		ni = bank_index(wb_adr_i, uecr_pkg::OFS_NAK, NUM_EP);
		next_rdata = uecr_pkg::RD_UNMAPPED;
		if (di < NUM_EP) next_rdata = {16'h0000, desc_rd[di]};
		else if (ni < NUM_EP) next_rdata = {27'h0, nak_rd[ni]};
		else begin
			unique case (wb_adr_i)
				uecr_pkg::OFS_SETUP_CMD_LO: next_rdata = setup_cmd[31:0];
				uecr_pkg::OFS_SETUP_CMD_HI: next_rdata = setup_cmd[63:32];
				uecr_pkg::OFS_SETUP_DAT_LO: next_rdata = setup_dat[31:0];
				uecr_pkg::OFS_SETUP_DAT_HI: next_rdata = setup_dat[63:32];
				uecr_pkg::OFS_SETUP_LEN: next_rdata = {16'h0000, setup_len};
				uecr_pkg::OFS_CONTROL: next_rdata = {16'h0000, ctl};
				uecr_pkg::OFS_ADDR_EP: next_rdata = {16'h0000, addr_ep};
				uecr_pkg::OFS_FRAME: next_rdata = {21'h0, frame_index};
				uecr_pkg::OFS_STALL: next_rdata = {16'h0000, stall_pol};
				uecr_pkg::OFS_DL_BASE: next_rdata = {14'h0, dl_base[0]};
				uecr_pkg::OFS_DL_BASE + 16'h0004: next_rdata = {14'h0, dl_base[1]};
				uecr_pkg::OFS_DL_BASE + 16'h0008: next_rdata = {14'h0, dl_base[2]};
				uecr_pkg::OFS_DL_WPTR: next_rdata = {14'h0, dl_wptr[0]};
				uecr_pkg::OFS_DL_WPTR + 16'h0004: next_rdata = {14'h0, dl_wptr[1]};
				uecr_pkg::OFS_DL_WPTR + 16'h0008: next_rdata = {14'h0, dl_wptr[2]};
				uecr_pkg::OFS_REGIO_ADDR: next_rdata = {16'h0000, rio_addr};
				uecr_pkg::OFS_REGIO_DATA: next_rdata = {16'h0000, rio_data};
				default: next_rdata = uecr_pkg::RD_UNMAPPED;
			endcase
		end
	end

	// Ack one cycle after the request; unmapped addresses ack with zero data.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? next_rdata : 32'h0;
		end
	end

	// Registered copies of the control state for the engine.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ep_halted_o <= '0;
			ep_short_pkt_o <= '0;
			bulk_halted_o <= 3'h0;
			ep0_stall_o <= 1'b0;
			in_data_o <= 64'h0;
			stage_length_o <= 4'h0;
			device_address_o <= 7'h00;
			ready_o <= 1'b0;
			reattach_o <= 1'b0;
			boot_from_ram_o <= 1'b0;
			regio_start_o <= 1'b0;
			regio_write_o <= 1'b0;
			regio_addr_o <= 14'h0000;
			regio_wdata_o <= 16'h0000;
			descriptor_o <= 144'h0;
		end else begin
			ep_halted_o <= halted_w; // [RULE5]
			ep_short_pkt_o <= short_w; // [RULE4]
			bulk_halted_o <= stall_pol[uecr_pkg::STALL_BULK_LSB +: 3]; // [RULE5]
			ep0_stall_o <= ctl[uecr_pkg::CTL_FAULT]; // [RULE19]
			in_data_o <= setup_dat;
			stage_length_o <= setup_len[3:0]; // [RULE12]
			device_address_o <= addr_ep[6:0]; // [RULE20]
			ready_o <= ctl[uecr_pkg::CTL_BOOT_DONE]; // [RULE15]
			reattach_o <= wr && wb_adr_i == uecr_pkg::OFS_CONTROL && wb_sel_i[0]
				&& wb_dat_i[uecr_pkg::CTL_REATTACH]; // [RULE16]
			boot_from_ram_o <= ctl[uecr_pkg::CTL_BOOT_RAM]; // [RULE17]
			regio_start_o <= rio_addr[uecr_pkg::RIO_START] && !regio_done_i; // [RULE13]
			regio_write_o <= rio_addr[uecr_pkg::RIO_WRITE];
			regio_addr_o <= rio_addr[13:0];
			regio_wdata_o <= rio_data; // [RULE14]
			// Descriptor bytes 8..16 are identity fields, left zero here and not set by any other path.
			descriptor_o <= {uecr_pkg::DD_NUM_CONFIG, 64'h0, 8'h00, uecr_pkg::DD_EP0_SIZE, uecr_pkg::DD_CLASS,
				uecr_pkg::DD_CLASS, uecr_pkg::DD_CLASS, uecr_pkg::DD_BCD_USB, 8'h01, uecr_pkg::DD_LENGTH}; // [RULE22]
		end
	end

	AST_WPTR_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && wb_adr_i == uecr_pkg::OFS_DL_BASE |=> dl_wptr[0] == 18'h3ffff) else $error("pointer not reset"); // [RULE9]
	AST_WPTR_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
		dl_write_i[1] && !(wr && wb_adr_i == uecr_pkg::OFS_DL_BASE + 16'h0004)
		|=> dl_wptr[1] == $past(dl_wptr[1]) + 18'h00001) else $error("pointer not advanced"); // [RULE8]
	AST_SETUP_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
		setup_valid_i |=> setup_cmd == $past(setup_bytes_i)) else $error("setup not captured"); // [RULE10]
	AST_FRAME: assert property (@(posedge clk_i) disable iff (rst_i)
		sof_valid_i |=> frame_index == $past(sof_frame_i)) else $error("frame not recorded"); // [RULE21]
	AST_IRQ_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_cause_i == 3'h1 |=> ctl[uecr_pkg::CTL_IRQ] && ctl[uecr_pkg::CTL_ISE]) else $error("irq cause lost"); // [RULE18]
	AST_REGIO_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
		regio_done_i && rio_addr[15] |=> !rio_addr[15] ##1 !regio_start_o) else $error("start not cleared"); // [RULE23]
	AST_EP0_STALL: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl[uecr_pkg::CTL_FAULT] |=> ep0_stall_o) else $error("ep0 not stalled"); // [RULE19]
	AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not single"); // [RULE13]
endmodule
`default_nettype wire

/* dv/uecr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Processor register space seen over register I/O.
// ----------------------------------------
module uecr_host_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic write_i,
	input wire logic [13:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [3:0] delay_i,
	output logic done_o = 1'b0,
	output logic [15:0] rdata_o = 16'h0000
);
	logic [15:0] mem [0:15];
	int cnt;
	logic busy;
	// One answer per start; read data toggles when not valid so a stale sample shows up.
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (rst_i) begin
			busy <= 1'b0;
			cnt <= 0;
		end else if (start_i && !busy) begin
			busy <= 1'b1;
			cnt <= delay_i + 1;
		end else if (busy) begin
			if (cnt == 1) begin
				done_o <= 1'b1;
				if (write_i) mem[addr_i[3:0]] <= wdata_i;
				else rdata_o <= mem[addr_i[3:0]];
			end
			if (cnt > 0) cnt <= cnt - 1;
			else if (!start_i) busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* dv/usb_endpoint_control_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bench for the endpoint control register set.
// ----------------------------------------
module usb_endpoint_control_regs_tb;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, setup_valid_i = 1'b0;
	logic out_data_valid_i = 1'b0, irq_clear_i = 1'b0, sof_valid_i = 1'b0, regio_done_i, h;
	logic [2:0] bulk_fifo_fault_i = 3'h0, dl_write_i = 3'h0, irq_cause_i = 3'h0, bulk_halted_o;
	logic [7:0] ep_done_i = 8'h00, ep_toggle_i = 8'h00, ep_fifo_fault_i = 8'h00, ep_halted_o, ep_short_pkt_o;
	logic [15:0] wb_adr_i = 16'h0000, ep_outcome_i = 16'h0000, regio_rdata_i, regio_wdata_o;
	logic [3:0] wb_sel_i = 4'hf, active_ep_i = 4'h0, dly = 4'h0, stage_length_o;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, lo;
	logic [63:0] setup_bytes_i = 64'h0, out_data_i = 64'h0, in_data_o, v;
	logic [10:0] sof_frame_i = 11'h0;
	logic wb_ack_o, ep0_stall_o, ready_o, reattach_o, boot_from_ram_o, regio_start_o, regio_write_o;
	logic [6:0] device_address_o;
	logic [13:0] regio_addr_o;
	logic [143:0] descriptor_o;
	int errors = 0, tests_run = 0, i, n, e, r;
	uecr_regs dut_u (.*);
	uecr_host_model host_u (.clk_i(clk_i), .rst_i(rst_i), .start_i(regio_start_o), .write_i(regio_write_o),
		.addr_i(regio_addr_o), .wdata_i(regio_wdata_o), .delay_i(dly), .done_o(regio_done_i), .rdata_o(regio_rdata_i));
	// The clock runs at 125 MHz.
	initial forever #4 clk_i = ~clk_i;
	task automatic chk(input logic [63:0] s, input logic [63:0] x);
		tests_run++;
		if (s !== x) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// Classic single cycle; the wait is bounded so a dead slave cannot hang the run.
	task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] o);
		int k;
		k = 0;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 64);
		o = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (k >= 64) errors++;
	endtask
	task tally_and_finish;
		$display("tests_run=%0d errors=%0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Guards against a hang.
	initial begin
		#400000;
		errors++;
		tally_and_finish();
	end
	// Main sequence.
	initial begin
		r = $urandom(22);
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 3; i++) begin
			e = $urandom & 32'h3ffff;
			wb(1'b1, 16'(uecr_pkg::OFS_DL_BASE + 4 * i), e, q);
			wb(1'b0, 16'(uecr_pkg::OFS_DL_BASE + 4 * i), 0, q);
			chk(q, e);
			wb(1'b0, 16'(uecr_pkg::OFS_DL_WPTR + 4 * i), 0, q);
			chk(q, 64'h3ffff);
			n = $urandom_range(1, 5);
			repeat (n) begin
				@(posedge clk_i) dl_write_i <= 3'(1 << i);
				@(posedge clk_i) dl_write_i <= 3'h0;
			end
			wb(1'b0, 16'(uecr_pkg::OFS_DL_WPTR + 4 * i), 0, q);
			chk(q, n - 1);
		end
		// Every kind and every outcome code, one per endpoint.
		for (i = 0; i < 8; i++) begin
			e = (($urandom & 1) << 14) | ((i % 4) << 12) | ($urandom & 32'h3ff);
			wb(1'b1, 16'(uecr_pkg::OFS_DESC + 8 * i), e, q);
			@(posedge clk_i) {ep_done_i, ep_outcome_i, ep_toggle_i} <= {8'(1 << i), 16'((i % 4) << 2 * i), 8'(i << i)};
			@(posedge clk_i) ep_done_i <= 8'h00;
			wb(1'b0, 16'(uecr_pkg::OFS_DESC + 8 * i), 0, q);
			chk(q, e | ((i % 2) << 15) | ((i % 4) << 10));
		end
		wb(1'b1, uecr_pkg::OFS_STALL, 32'h12a, q);
		@(posedge clk_i) {ep_done_i, ep_outcome_i} <= {8'h01, 16'h0002};
		@(posedge clk_i) ep_done_i <= 8'h00;
		repeat (2) @(posedge clk_i);
		chk({bulk_halted_o, ep_short_pkt_o[0]}, 4'b1010);
		@(posedge clk_i) {ep_done_i, ep_fifo_fault_i} <= 16'h0102;
		@(posedge clk_i) {ep_done_i, ep_fifo_fault_i} <= 16'h0000;
		h = 1'b0;
		repeat (3) @(posedge clk_i) h |= ep_short_pkt_o[0];
		chk({h, ep_halted_o[1]}, 2'b11);
		wb(1'b0, uecr_pkg::OFS_NAK + 16'h0008, 0, q);
		chk(q, 32'h10);
		v = {$urandom, $urandom};
		@(posedge clk_i) {setup_valid_i, setup_bytes_i, sof_valid_i, sof_frame_i} <= {1'b1, v, 1'b1, v[10:0]};
		@(posedge clk_i) {setup_valid_i, sof_valid_i} <= 2'b00;
		wb(1'b0, uecr_pkg::OFS_SETUP_CMD_LO, 0, lo);
		wb(1'b0, uecr_pkg::OFS_SETUP_CMD_HI, 0, q);
		chk({q, lo}, v);
		wb(1'b0, uecr_pkg::OFS_FRAME, 0, q);
		chk(q, v[10:0]);
		wb(1'b1, uecr_pkg::OFS_CONTROL, 32'h5, q);
		@(posedge clk_i);
		chk({ready_o, boot_from_ram_o}, 2'b11);
		wb(1'b1, uecr_pkg::OFS_ADDR_EP, 32'h5a, q);
		wb(1'b1, uecr_pkg::OFS_SETUP_LEN, 32'h7, q);
		wb(1'b1, uecr_pkg::OFS_CONTROL, 32'h87, q);
		h = reattach_o;
		@(posedge clk_i) {irq_cause_i, active_ep_i, out_data_valid_i, bulk_fifo_fault_i, out_data_i} <= {11'h29a, ~v};
		chk({h, reattach_o, ep0_stall_o, ready_o}, 4'hb);
		chk({stage_length_o, device_address_o}, 11'h3da);
		@(posedge clk_i) {irq_cause_i, out_data_valid_i, bulk_fifo_fault_i} <= 7'h0;
		repeat (2) @(posedge clk_i);
		chk(in_data_o, ~v);
		chk(bulk_halted_o, 3'h7);
		wb(1'b0, uecr_pkg::OFS_CONTROL, 0, q);
		chk(q, 32'haf);
		wb(1'b0, uecr_pkg::OFS_ADDR_EP, 0, q);
		chk(q, 32'h95a);
		// Register I/O write, then read back, random delay.
		for (i = 0; i < 4; i++) begin
			e = $urandom & 32'hffff;
			dly <= 4'($urandom_range(0, 7));
			wb(1'b1, uecr_pkg::OFS_REGIO_DATA, e, q);
			wb(1'b1, uecr_pkg::OFS_REGIO_ADDR, 32'hc000 | i, q);
			for (r = 0; r < 2; r++) begin
				n = 0;
				do begin
					wb(1'b0, uecr_pkg::OFS_REGIO_ADDR, 0, q);
					n++;
				end while (q[15] && n < 20);
				chk(q[15:0], (r ? 32'h0000 : 32'h4000) | i);
				if (r == 0) begin
					wb(1'b1, uecr_pkg::OFS_REGIO_DATA, 32'h0, q);
					wb(1'b1, uecr_pkg::OFS_REGIO_ADDR, 32'h8000 | i, q);
				end
			end
			wb(1'b0, uecr_pkg::OFS_REGIO_DATA, 0, q);
			chk(q, e);
		end
		wb(1'b0, 16'h0020, 0, q);
		chk(q, 0);
		chk({descriptor_o[143:136], descriptor_o[63:56], descriptor_o[31:16], descriptor_o[7:0]}, 40'h0108011012);
		tally_and_finish();
	end
endmodule
`default_nettype wire
